// File: inc/spims_pkg.sv
package spims_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses on the register bus)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;

    // ------------------------------------------------------------
    // serial_mode_enable fields
    // ------------------------------------------------------------
    localparam int MODE_ROLE_LSB = 5;
    localparam int MODE_UART_BIT = 4;
    localparam int MODE_DEB_LSB = 2;
    localparam int MODE_EN_BIT = 1;
    localparam int MODE_INC_BIT = 0;

    // ------------------------------------------------------------
    // spi_control_status fields
    // ------------------------------------------------------------
    localparam int CTRL_SPARE_LSB = 6;
    localparam int CTRL_POL_BIT = 5;
    localparam int CTRL_EDGE_BIT = 4;
    localparam int CTRL_ORDER_BIT = 3;
    localparam int CTRL_SELECT_PIN_ENABLE_BIT = 2;
    localparam int CTRL_WRITE_COLLISION_FLAG_BIT = 1;
    localparam int CTRL_DONE_BIT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_MODE = 8'hE0;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;

    // ------------------------------------------------------------
    // role and clock codes of serial_role_clock_field
    // ------------------------------------------------------------
    localparam logic [2:0] ROLE_DIV4 = 3'h0;
    localparam logic [2:0] ROLE_DIV16 = 3'h1;
    localparam logic [2:0] ROLE_DIV64 = 3'h2;
    localparam logic [2:0] ROLE_SUB = 3'h3;
    localparam logic [2:0] ROLE_TIMER = 3'h4;
    localparam logic [2:0] ROLE_SLAVE = 3'h5;

    // ------------------------------------------------------------
    // timing counts (last values: divider per half serial period, edges and bits per byte)
    // ------------------------------------------------------------
    localparam logic [5:0] DIV4_LAST = 6'h01;
    localparam logic [5:0] DIV16_LAST = 6'h07;
    localparam logic [5:0] DIV64_LAST = 6'h1F;
    localparam logic [3:0] EDGE_LAST = 4'hF;
    localparam logic [3:0] BIT_LAST = 4'h7;

    // master sequencer states
    typedef enum logic {SPIMS_IDLE, SPIMS_SHIFT} spims_state_t;

endpackage

// File: rtl/spims_top.sv
// Overview of operation
// - protocol select must be 0 for SPI
// - mode field picks role and master clock
// - slave takes clock, master makes it
// - enable off releases pins, idles logic
// - enabling keeps control register contents
// - early select release sets incomplete and done
// - incomplete condition raises interrupt request
// - software incomplete write never sets done
// - polarity bit sets clock idle level
// - capture edge bit picks sampling edge
// - order bit selects msb or lsb first
// - select enable makes select pin active
// - data write while busy dropped, collision flagged
// - done flag set by hardware, cleared by software
// - master data write starts full duplex transfer
// - slave shifts on each master clock
// - keeps running while its clock runs
// - two spare control bits read and write
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
module spims_top
(
    // system
    input wire logic clk_sys,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic slave_select_n,
    // master clock sources
    input wire logic sub_clock,
    input wire logic timer_match_clock,
    // interrupt
    input wire logic irq_enable,
    output logic serial_irq
);
    import spims_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // each pin crosses two flops before use; s1 may be metastable,
    // so only s2 ever reads it
    logic [4:0] pin_raw;
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [4:0] pin_s3;

    // bit 4 sck, 3 sdi, 2 select, 1 sub clock, 0 timer match
    assign pin_raw = {sck_in, sdi, slave_select_n, sub_clock,
                      timer_match_clock};

    // s3 is a history copy for edge detection, never of s1
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1 <= 5'h1F;
            pin_s2 <= 5'h1F;
            pin_s3 <= 5'h1F;
        end
        else
        begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] serial_mode_enable;
    logic [7:0] spi_control_status;
    logic [7:0] shift_data_reg;
    spims_state_t state;
    // the master counts sck toggles, sixteen a byte; the slave
    // counts captured bits, eight a byte
    logic [3:0] edge_cnt;
    logic [3:0] slave_bits;
    logic [5:0] div_cnt;

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    // codes 6 and 7 and the uart setting leave both roles off, so
    // the pins are released and no shifting can start
    wire [2:0] serial_role_clock_field =
        serial_mode_enable[MODE_ROLE_LSB +: 3];
    wire uart_protocol_select = serial_mode_enable[MODE_UART_BIT];
    wire iface_enable = serial_mode_enable[MODE_EN_BIT];
    wire slave_incomplete_flag = serial_mode_enable[MODE_INC_BIT];
    wire clock_idle_polarity = spi_control_status[CTRL_POL_BIT];
    wire capture_edge_select = spi_control_status[CTRL_EDGE_BIT];
    wire shift_order_select = spi_control_status[CTRL_ORDER_BIT];
    wire select_pin_enable = spi_control_status[CTRL_SELECT_PIN_ENABLE_BIT];

    // spi only with uart deselected and the interface enabled
    wire spi_on = iface_enable & ~uart_protocol_select;
    wire is_master = spi_on & (serial_role_clock_field <= ROLE_TIMER);
    wire is_slave = spi_on & (serial_role_clock_field == ROLE_SLAVE);
    // polarity 0 idles the clock high
    wire idle_lvl = ~clock_idle_polarity;
    // capture on the leading edge exactly when the edge bit is 1
    wire lead_cap = capture_edge_select;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // only three words decode; any other address answers with
    // pslverr and leaves every register untouched
    wire apb_setup = psel & ~penable;
    wire apb_done = psel & penable & pready;
    wire hit_mode = (paddr == OFF_MODE);
    wire hit_ctrl = (paddr == OFF_CTRL);
    wire hit_data = (paddr == OFF_DATA);
    wire hit_any = hit_mode | hit_ctrl | hit_data;
    wire wr_mode = apb_done & pwrite & hit_mode;
    wire wr_ctrl = apb_done & pwrite & hit_ctrl;
    wire wr_data = apb_done & pwrite & hit_data;
    wire [7:0] rd_byte = hit_mode ? serial_mode_enable :
                         hit_ctrl ? spi_control_status :
                         hit_data ? shift_data_reg : 8'h00;

    // answer one cycle after setup: no wait states
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~hit_any;
            prdata <= (apb_setup & ~pwrite) ? {24'h00_0000, rd_byte}
                                            : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // master clock source
    // ------------------------------------------------------------
    // the divider measures one half serial period in system cycles:
    // /4 toggles every second cycle, /16 every eighth and /64
    // every thirty-second
    wire [5:0] div_last =
        (serial_role_clock_field == ROLE_DIV4) ? DIV4_LAST :
        (serial_role_clock_field == ROLE_DIV16) ? DIV16_LAST : DIV64_LAST;
    wire div_hit = (div_cnt == div_last);
    // both outside sources are slow, so the two flop delay moves
    // only the phase of the serial clock, never its rate
    // every sub clock edge is one half period of the serial clock
    wire sub_edge = pin_s2[1] ^ pin_s3[1];
    // each match pulse toggles the clock, giving match rate halved
    wire tm_rise = pin_s2[0] & ~pin_s3[0];
    wire src_tick =
        (serial_role_clock_field == ROLE_SUB) ? sub_edge :
        (serial_role_clock_field == ROLE_TIMER) ? tm_rise : div_hit;
    wire m_busy = (state == SPIMS_SHIFT);
    wire tick = is_master & m_busy & src_tick;

    // divider restarts per transfer so the first half period is whole
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            div_cnt <= 6'h00;
        else if (!m_busy || div_hit)
            div_cnt <= 6'h00;
        else
            div_cnt <= div_cnt + 6'h01;
    end

    // ------------------------------------------------------------
    // edge classification
    // ------------------------------------------------------------
    // received data passes the same two flops, so the far side has
    // half a serial period less two system cycles to settle; at /4
    // that leaves no margin, /16 or slower is the safe choice
    // even edge count is a leading edge
    wire m_cap = tick & (edge_cnt[0] ^ lead_cap);
    wire m_launch = tick & ~(edge_cnt[0] ^ lead_cap);
    wire m_end = tick & (edge_cnt == EDGE_LAST);

    // a slave needs three system cycles per sck half period, or the
    // synchroniser merges two edges of the master into one
    // unused select pin means the slave is always addressed
    wire sel_pin_low = ~pin_s2[2];
    wire selected = ~select_pin_enable | sel_pin_low;
    wire sck_lead = (pin_s3[4] == idle_lvl) & (pin_s2[4] != idle_lvl);
    wire sck_trail = (pin_s3[4] != idle_lvl) & (pin_s2[4] == idle_lvl);
    wire sl_go = is_slave & selected;
    wire sl_cap = sl_go & (lead_cap ? sck_lead : sck_trail);
    wire sl_launch = sl_go & (lead_cap ? sck_trail : sck_lead);
    wire sl_end = sl_cap & (slave_bits == BIT_LAST);
    wire sl_busy = (slave_bits != 4'h0);
    // select released mid byte while the pin is in use
    wire sel_rise = pin_s2[2] & ~pin_s3[2];
    wire inc_set = is_slave & select_pin_enable & sel_rise & sl_busy;

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    // one shifter serves both roles; only the strobes differ, so a
    // role change between bytes needs no flush, but leaving the
    // role mid byte abandons that byte without raising done
    wire busy = m_busy | sl_busy;
    // a write while shifting is dropped, not merged into the byte
    wire load = wr_data & ~busy;
    wire write_collision_flag_set = wr_data & busy;
    wire done_set = m_end | sl_end | inc_set;
    wire sh_top = shift_order_select ? shift_data_reg[7]
                                     : shift_data_reg[0];
    wire wd_top = shift_order_select ? pwdata[7] : pwdata[0];
    wire [7:0] shifted = shift_order_select ?
        {shift_data_reg[6:0], pin_s2[3]} :
        {pin_s2[3], shift_data_reg[7:1]};
    wire [7:0] next_data = load ? pwdata[7:0] :
                           (m_cap | sl_cap) ? shifted : shift_data_reg;
    wire next_sdo = load ? wd_top :
                    (m_launch | sl_launch) ? sh_top : sdo_out;

    // the data register is the shifter, so reads see received bits
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_data_reg <= RST_DATA;
            sdo_out <= 1'b1;
        end
        else
        begin
            shift_data_reg <= next_data;
            sdo_out <= next_sdo;
        end
    end

    // ------------------------------------------------------------
    // master sequencer
    // ------------------------------------------------------------
    // the clock follows the polarity bit while idle, so changing it
    // mid byte would add a false edge once the byte ends and the clock returns to idle
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= SPIMS_IDLE;
            edge_cnt <= 4'h0;
            sck_out <= 1'b1;
        end
        else if (!is_master)
        begin
            state <= SPIMS_IDLE;
            edge_cnt <= 4'h0;
            sck_out <= idle_lvl;
        end
        else
        begin
            unique case (state)
                SPIMS_IDLE:
                begin
                    sck_out <= idle_lvl;
                    edge_cnt <= 4'h0;
                    if (load)
                        state <= SPIMS_SHIFT;
                end
                SPIMS_SHIFT:
                begin
                    if (tick)
                    begin
                        sck_out <= ~sck_out;
                        edge_cnt <= edge_cnt + 4'h1;
                    end
                    if (m_end)
                        state <= SPIMS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // slave bit counter
    // ------------------------------------------------------------
    // cleared when the role is left, so a stale count cannot linger
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            slave_bits <= 4'h0;
        else if (!is_slave || sl_end || inc_set)
            slave_bits <= 4'h0;
        else if (sl_cap)
            slave_bits <= slave_bits + 4'h1;
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // the incomplete flag sits in the mode register, so every mode
    // write must carry its current value or it clears the flag
    // hardware set wins over a software clear in the same cycle
    wire next_inc = inc_set |
        (wr_mode ? pwdata[MODE_INC_BIT] : slave_incomplete_flag);
    wire next_write_collision_flag = write_collision_flag_set |
        (wr_ctrl ? pwdata[CTRL_WRITE_COLLISION_FLAG_BIT]
                 : spi_control_status[CTRL_WRITE_COLLISION_FLAG_BIT]);
    wire next_done = done_set |
        (wr_ctrl ? pwdata[CTRL_DONE_BIT]
                 : spi_control_status[CTRL_DONE_BIT]);
    wire [7:0] next_mode = wr_mode ?
        {pwdata[7:MODE_INC_BIT + 1], next_inc} :
        {serial_mode_enable[7:MODE_INC_BIT + 1], next_inc};
    // spare bits and settings are plain storage
    wire [5:0] ctrl_cfg = wr_ctrl ? pwdata[7:CTRL_WRITE_COLLISION_FLAG_BIT + 1]
                                  : spi_control_status[7:2];
    wire [7:0] next_ctrl = {ctrl_cfg, next_write_collision_flag, next_done};

    // enable does not touch these, settings survive re-enabling
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serial_mode_enable <= RST_MODE;
            spi_control_status <= RST_CTRL;
        end
        else
        begin
            serial_mode_enable <= next_mode;
            spi_control_status <= next_ctrl;
        end
    end

    // ------------------------------------------------------------
    // pin enables and interrupt
    // ------------------------------------------------------------
    // the interrupt pulses once per hardware set of done; software
    // writing 1 to either flag raises nothing
    // disabled interface drives nothing and lets the pins go
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sck_oe <= 1'b0;
            sdo_oe <= 1'b0;
            serial_irq <= 1'b0;
        end
        else
        begin
            sck_oe <= is_master;
            sdo_oe <= is_master | sl_go;
            serial_irq <= irq_enable & done_set;
        end
    end

endmodule

// File: bench/spims_properties.sv
module spims_properties
(
    // system
    input wire logic clk_sys,
    input wire logic rst_b,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // serial and interrupt
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic sdo_oe,
    input wire logic irq_enable,
    input wire logic serial_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import spims_pkg::*;

    // ------
    // bus and link checks
    // ------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // only three words answer without error
    wire logic mapped;
    assign mapped = paddr == OFF_MODE || paddr == OFF_CTRL
        || paddr == OFF_DATA;

    a_ready_after_setup: assert property (psel && !penable ##1 psel
        && penable |-> pready) else $error("pready late");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_unmapped: assert property (pslverr |-> pready && !mapped)
        else $error("pslverr on mapped word");
    a_unmapped_err: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped word accepted");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata outside access");
    a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_irq_pulse: assert property (serial_irq |=> !serial_irq)
        else $error("irq longer than a cycle");
    a_irq_gated: assert property (!irq_enable ##1 !irq_enable
        |-> !serial_irq) else $error("irq while disabled");
    // fastest divider toggles every second cycle
    a_sck_spacing: assert property (sck_oe && $changed(sck_out)
        |=> $stable(sck_out)) else $error("sck too fast");
    a_master_drives: assert property (sck_oe |-> sdo_oe)
        else $error("master without data out");

    cover property (serial_irq);
    cover property (pslverr);
    cover property (sck_oe && $changed(sck_out));
endmodule

bind spims_top spims_properties u_spims_properties
(
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sck_out(sck_out),
    .sck_oe(sck_oe),
    .sdo_oe(sdo_oe),
    .irq_enable(irq_enable),
    .serial_irq(serial_irq)
);

// File: bench/spims_slave_model.sv
module spims_slave_model
(
    // serial lines
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    output logic miso,
    // setup and data
    input wire logic lead_cap,
    input wire logic msb_first,
    input wire logic [7:0] tx,
    output logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;

    function automatic logic pick(input int j);
        return msb_first ? tx[7 - j] : tx[j];
    endfunction

    // leading capture needs the first bit before any edge
    always @(negedge sel_n)
    begin
        n = 0;
        if (lead_cap)
            miso = pick(0);
    end

    // a released line shows the inverse, never a stale bit
    always @(posedge sel_n)
        miso = ~miso;

    // odd edges lead; capture on one kind, launch on the other
    always @(sck)
    begin
        if (sel_n === 1'h0)
        begin
            n++;
            if ((n % 2 == 1) == lead_cap)
                rx = msb_first ? {rx[6:0], mosi} : {mosi, rx[7:1]};
            else if (n / 2 < 8)
                miso = pick(n / 2);
        end
    end
endmodule

// File: bench/spims_top_test.sv
module spims_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import spims_pkg::*;

    // ------
    // signals
    // ------
    logic clk_sys = 1'h0;
    logic rst_b = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sck_in = 1'h1;
    logic sck_out;
    logic sck_oe;
    logic sdi;
    logic sdo_out;
    logic sdo_oe;
    logic ss_n = 1'h1;
    logic sub_clock = 1'h0;
    logic timer_match_clock = 1'h0;
    logic irq_enable = 1'h1;
    logic serial_irq;
    logic sel_n = 1'h1;
    logic lead = 1'h0;
    logic msb = 1'h0;
    logic [7:0] slv_tx = 8'h00;
    logic [7:0] slv_rx;
    int fails = 0;
    int cmp_count = 0;
    int irqs = 0;

    // clock sources all toggle on falling clk_sys edges, so the sync paths see one fixed phase
    always #50 clk_sys = ~clk_sys;
    always #800 sub_clock = ~sub_clock;
    always #1300 timer_match_clock = ~timer_match_clock;
    always @(posedge clk_sys)
        if (serial_irq === 1'h1)
            irqs++;

    spims_top u_spims_top
    (
        .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out),
        .sck_oe(sck_oe), .sdi(sdi), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .slave_select_n(ss_n),
        .sub_clock(sub_clock), .timer_match_clock(timer_match_clock),
        .irq_enable(irq_enable), .serial_irq(serial_irq)
    );

    spims_slave_model u_spims_slave_model
    (
        .sck(sck_out), .mosi(sdo_out), .sel_n(sel_n), .miso(sdi),
        .lead_cap(lead), .msb_first(msb), .tx(slv_tx), .rx(slv_rx)
    );

    // ------
    // shared tasks
    // ------
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    // one setup and one access phase, held until pready
    task automatic apb(input logic w, input logic [7:0] a, d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'h1 && n < 50);
        if (n >= 50)
        begin
            chk(0, 1, "no pready");
            report_and_stop();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
        input string m);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 8'h00, r, e);
        chk(r, x, m);
    endtask

    // polling is bounded; a stuck flag ends the run
    task automatic wait_done(output logic [31:0] r);
        logic e;
        int n;
        n = 0;
        do
        begin
            apb(1'h0, OFF_CTRL, 8'h00, r, e);
            n++;
        end
        while (r[CTRL_DONE_BIT] !== 1'h1 && n < 400);
        if (n >= 400)
        begin
            chk(0, 1, "no done");
            report_and_stop();
        end
    endtask

    // ------
    // scenarios
    // ------
    task automatic reg_reset;
        logic [31:0] r;
        logic e;
        rd(OFF_MODE, RST_MODE, "mode reset");
        rd(OFF_CTRL, RST_CTRL, "ctrl reset");
        rd(OFF_DATA, RST_DATA, "data reset");
        apb(1'h0, 8'h0C, 8'h00, r, e);
        chk(e, 1, "unmapped err");
        chk(r, 0, "unmapped data");
        $display("test reg_reset done");
    endtask

    task automatic enable_keep;
        wr(OFF_MODE, {ROLE_DIV16, 5'h02});
        wr(OFF_CTRL, 8'hE8);
        wr(OFF_MODE, {ROLE_DIV16, 5'h00});
        repeat (2) @(posedge clk_sys);
        chk(sck_oe, 0, "disabled clock");
        wr(OFF_MODE, {ROLE_DIV16, 5'h02});
        rd(OFF_CTRL, 8'hE8, "ctrl kept");
        $display("test enable_keep done");
    endtask

    task automatic master_xfer(input logic [2:0] role,
        input logic [7:0] ctrl, tx, srx, input logic ie);
        logic [31:0] r;
        int irq0;
        lead <= ctrl[CTRL_EDGE_BIT];
        msb <= ctrl[CTRL_ORDER_BIT];
        slv_tx <= srx;
        irq_enable <= ie;
        wr(OFF_CTRL, ctrl);
        wr(OFF_MODE, {role, 5'h02});
        repeat (2) @(posedge clk_sys);
        chk(sck_out, {31'h0, ~ctrl[CTRL_POL_BIT]}, "idle level");
        chk(sck_oe, 1, "master clock");
        chk(sdo_oe, 1, "data out on");
        sel_n <= 1'h0;
        irq0 = irqs;
        wr(OFF_DATA, tx);
        wr(OFF_DATA, ~tx);
        wait_done(r);
        chk(r[CTRL_WRITE_COLLISION_FLAG_BIT], 1, "collision");
        rd(OFF_DATA, srx, "rx byte");
        chk(slv_rx, tx, "tx byte");
        chk(32'(irqs - irq0), {31'h0, ie}, "irq count");
        sel_n <= 1'h1;
        wr(OFF_CTRL, ctrl);
        rd(OFF_CTRL, ctrl, "flags cleared");
        $display("test master_xfer role %0d done", role);
    endtask

    task automatic slave_abort;
        logic [31:0] r;
        int irq0;
        irq_enable <= 1'h1;
        wr(OFF_CTRL, 8'h04);
        wr(OFF_MODE, {ROLE_SLAVE, 5'h02});
        repeat (2) @(posedge clk_sys);
        chk(sck_oe, 0, "slave clock");
        irq0 = irqs;
        ss_n <= 1'h0;
        // three edges leave a single captured bit
        repeat (3)
        begin
            repeat (4) @(posedge clk_sys);
            sck_in <= ~sck_in;
        end
        repeat (4) @(posedge clk_sys);
        ss_n <= 1'h1;
        wait_done(r);
        rd(OFF_MODE, {ROLE_SLAVE, 5'h03}, "incomplete");
        chk(32'(irqs - irq0), 1, "abort irq");
        sck_in <= 1'h1;
        wr(OFF_CTRL, 8'h04);
        wr(OFF_MODE, {ROLE_SLAVE, 5'h02});
        wr(OFF_MODE, {ROLE_SLAVE, 5'h03});
        rd(OFF_CTRL, 8'h04, "sw incomplete");
        rd(OFF_MODE, {ROLE_SLAVE, 5'h03}, "sw set");
        $display("test slave_abort done");
    endtask

    // ------
    // main sequence
    // ------
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'h1;
        reg_reset();
        enable_keep();
        master_xfer(ROLE_DIV16, 8'h08, 8'hA5, 8'h3C, 1'h1);
        master_xfer(ROLE_DIV64, 8'h30, 8'h96, 8'h5A, 1'h1);
        master_xfer(ROLE_SUB, 8'h18, 8'hC3, 8'h81, 1'h0);
        master_xfer(ROLE_TIMER, 8'h20, 8'h0F, 8'hF0, 1'h1);
        slave_abort();
        report_and_stop();
    end
endmodule
